// >>> design/tgc_pkg.sv
// Package with register map, field positions, reset values and modes of the gate and capture block
package tgc_pkg;
    localparam logic [7:0] OFS_GATE_CTRL = 8'h00;
    localparam logic [7:0] OFS_MAIN_TIMER = 8'h04;
    localparam logic [7:0] OFS_CAPTURE = 8'h08;
    localparam logic [7:0] OFS_CAPTURE_CTRL = 8'h0c;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;

    localparam int GC_SOURCE_LSB = 0;
    localparam int GC_LEVEL_BIT = 2;
    localparam int GC_ARMED_BIT = 3;
    localparam int GC_SINGLE_BIT = 4;
    localparam int GC_TOGGLE_BIT = 5;
    localparam int GC_POLARITY_BIT = 6;
    localparam int GC_ENABLE_BIT = 7;
    localparam int GC_TIMER_ON_BIT = 8;
    localparam int IRQ_GATE_BIT = 0;
    localparam int IRQ_CAPTURE_BIT = 1;

    localparam logic [3:0] CAP_OFF = 4'h0;
    localparam logic [3:0] CAP_FALL = 4'h4;
    localparam logic [3:0] CAP_RISE = 4'h5;
    localparam logic [3:0] CAP_RISE4 = 4'h6;
    localparam logic [3:0] CAP_RISE16 = 4'h7;
    localparam logic [3:0] CAP_PRE4_LAST = 4'h3;
    localparam logic [3:0] CAP_PRE16_LAST = 4'hf;

    localparam logic [7:0] OVF_FROM = 8'hff;
    localparam logic [7:0] OVF_TO = 8'h00;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        SRC_PIN = 2'b00,
        SRC_OVERFLOW = 2'b01,
        SRC_CMP1 = 2'b10,
        SRC_CMP2 = 2'b11
    } gate_src_t;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_WAIT = 2'b01,
        SP_RUN = 2'b10
    } sp_state_t;

    typedef struct packed {
        logic timer_on;
        logic gate_enable;
        logic gate_polarity;
        logic gate_toggle_enable;
        logic gate_single_pulse_enable;
        gate_src_t gate_source_select;
    } gate_ctrl_t;

    typedef struct packed {
        logic cmp1_out;
        logic cmp1_sync_en;
        logic cmp2_out;
        logic cmp2_sync_en;
    } cmp_in_t;
endpackage

// >>> design/capture_unit.sv
// Capture event detector with edge select and rising-edge prescaler
`timescale 1ns/1ns
module capture_unit
    import tgc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_pin_level,
    input wire logic [3:0] i_mode,
    output logic o_event
);
    logic pin_prev;
    logic [3:0] pre_cnt;
    logic next_pin_prev;
    logic [3:0] next_pre_cnt;
    logic rise;
    logic fall;

    function automatic logic pre_hit(input logic [3:0] cnt, input logic [3:0] last);
        pre_hit = (cnt == last);
    endfunction

    always_comb begin
        rise = i_pin_level & ~pin_prev;
        fall = ~i_pin_level & pin_prev;
        next_pin_prev = i_pin_level;
        next_pre_cnt = pre_cnt;
        o_event = 1'b0;
        case (i_mode)
            CAP_FALL: begin
                o_event = fall;
            end
            CAP_RISE: begin
                o_event = rise;
            end
            CAP_RISE4: begin
                if (rise) begin
                    o_event = pre_hit(pre_cnt, CAP_PRE4_LAST);
                    next_pre_cnt = o_event ? 4'h0 : pre_cnt + 4'h1;
                end
            end
            CAP_RISE16: begin
                if (rise) begin
                    o_event = pre_hit(pre_cnt, CAP_PRE16_LAST);
                    next_pre_cnt = o_event ? 4'h0 : pre_cnt + 4'h1;
                end
            end
            default: begin
                next_pre_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pin_prev <= 1'b0;
            pre_cnt <= 4'h0;
        end else begin
            pin_prev <= next_pin_prev;
            pre_cnt <= next_pre_cnt;
        end
    end
endmodule

// >>> design/timer_gate_and_capture.sv
// Main timer gate control, gate status and event flag, and capture unit behind APB
`timescale 1ns/1ns
// Behaviour
// - Two-bit select picks gate source
// - Polarity bit applies to chosen source
// - Overflow timer rollover makes gate pulse
// - Comparator gate synced or raw per config
// - Toggle mode flips on each incrementing edge
// - Toggle disabled holds flip-flop at zero
// - Arm single pulse; starts on next edge
// - Trailing edge disarms; blocks later gate events
// - Toggle plus single pulse measures one cycle
// - Gate level readable even gating disabled
// - Gate level falling edge sets flag, interrupt
// - Gate flag works with gating disabled
// - Capture copies sixteen-bit timer value
// - Mode picks falling, rising, 4th, 16th
// - Capture flag set by hardware, software clears
// - New capture overwrites previous value
// - Pin driven as output still triggers capture
module timer_gate_and_capture
    import tgc_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_gate_input_pin,
    input wire logic [7:0] i_overflow_timer_count,
    input wire cmp_in_t i_cmp,
    input wire logic i_capture_pin,
    input wire logic i_pin_direction_bit,
    input wire logic i_port_latch,
    output logic [TIMER_W-1:0] o_main_timer,
    output logic o_gate_irq,
    output logic o_capture_irq
);
    if (TIMER_W != 16) begin : g_width_check
        $error("TIMER_W must be 16");
    end

    gate_ctrl_t ctrl;
    gate_ctrl_t next_ctrl;
    sp_state_t sp_state;
    sp_state_t next_sp_state;
    logic [3:0] capture_mode_select;
    logic [3:0] next_capture_mode_select;
    logic [1:0] irq_enable_reg;
    logic [1:0] next_irq_enable_reg;
    logic gate_event_flag;
    logic next_gate_event_flag;
    logic capture_flag;
    logic next_capture_flag;
    logic [TIMER_W-1:0] next_main_timer;
    logic [TIMER_W-1:0] capture_reg;
    logic [TIMER_W-1:0] next_capture_reg;
    logic [7:0] ovf_prev;
    logic cmp1_sync;
    logic cmp2_sync;
    logic gate_in_prev;
    logic toggle_ff;
    logic next_toggle_ff;
    logic toggled_prev;
    logic gate_level_status;
    logic next_gate_level_status;
    logic next_gate_irq;
    logic next_capture_irq;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic overflow_pulse;
    logic cmp1_sel;
    logic cmp2_sel;
    logic gate_raw;
    logic gate_in;
    logic gate_in_rise;
    logic toggled;
    logic toggled_rise;
    logic count_en;
    logic wr;
    logic capture_event;
    logic capture_pin_level;

    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
        addr_hit = (addr == ofs);
    endfunction

    assign wr = i_psel & i_penable & o_pready & i_pwrite;
    assign capture_pin_level = i_pin_direction_bit ? i_capture_pin : i_port_latch;

    // Capture edge detector and prescaler
    capture_unit u_capture (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_pin_level(capture_pin_level),
        .i_mode(capture_mode_select),
        .o_event(capture_event)
    );

    // Gate source path
    always_comb begin
        overflow_pulse = (ovf_prev == OVF_FROM) && (i_overflow_timer_count == OVF_TO);
        cmp1_sel = i_cmp.cmp1_sync_en ? cmp1_sync : i_cmp.cmp1_out;
        cmp2_sel = i_cmp.cmp2_sync_en ? cmp2_sync : i_cmp.cmp2_out;
        case (ctrl.gate_source_select)
            SRC_PIN: gate_raw = i_gate_input_pin;
            SRC_OVERFLOW: gate_raw = overflow_pulse;
            SRC_CMP1: gate_raw = cmp1_sel;
            SRC_CMP2: gate_raw = cmp2_sel;
            default: gate_raw = 1'b0;
        endcase
        gate_in = ctrl.gate_polarity ? gate_raw : ~gate_raw;
        gate_in_rise = gate_in & ~gate_in_prev;
        // Toggle stage
        if (ctrl.gate_toggle_enable) begin
            next_toggle_ff = toggle_ff ^ gate_in_rise;
        end else begin
            next_toggle_ff = 1'b0;
        end
        toggled = ctrl.gate_toggle_enable ? toggle_ff : gate_in;
        toggled_rise = toggled & ~toggled_prev;
    end

    // Control, status and timer state
    always_comb begin
        next_ctrl = ctrl;
        next_sp_state = sp_state;
        next_capture_mode_select = capture_mode_select;
        next_irq_enable_reg = irq_enable_reg;
        next_capture_reg = capture_reg;
        next_main_timer = o_main_timer;
        // Single-pulse sequencing, chained after the toggle stage
        case (sp_state)
            SP_WAIT: begin
                if (toggled_rise) begin
                    next_sp_state = SP_RUN;
                end
            end
            SP_RUN: begin
                if (!toggled) begin
                    next_sp_state = SP_IDLE;
                end
            end
            default: begin
                next_sp_state = SP_IDLE;
            end
        endcase
        if (ctrl.gate_single_pulse_enable) begin
            next_gate_level_status = (sp_state == SP_WAIT && toggled_rise)
                || (sp_state == SP_RUN && toggled);
        end else begin
            next_gate_level_status = toggled;
        end
        count_en = ctrl.timer_on && (!ctrl.gate_enable || gate_level_status);
        if (count_en) begin
            next_main_timer = o_main_timer + 16'h0001;
        end
        next_gate_event_flag = gate_event_flag;
        next_capture_flag = capture_flag;
        // Register writes
        if (wr) begin
            if (addr_hit(i_paddr, OFS_GATE_CTRL)) begin
                next_ctrl.timer_on = i_pwdata[GC_TIMER_ON_BIT];
                next_ctrl.gate_enable = i_pwdata[GC_ENABLE_BIT];
                next_ctrl.gate_polarity = i_pwdata[GC_POLARITY_BIT];
                next_ctrl.gate_toggle_enable = i_pwdata[GC_TOGGLE_BIT];
                next_ctrl.gate_single_pulse_enable = i_pwdata[GC_SINGLE_BIT];
                next_ctrl.gate_source_select = gate_src_t'(i_pwdata[GC_SOURCE_LSB +: 2]);
                if (!i_pwdata[GC_ARMED_BIT]) begin
                    next_sp_state = SP_IDLE;
                end else if (sp_state == SP_IDLE) begin
                    next_sp_state = SP_WAIT;
                end
            end
            if (addr_hit(i_paddr, OFS_MAIN_TIMER)) begin
                next_main_timer = i_pwdata[TIMER_W-1:0];
            end
            if (addr_hit(i_paddr, OFS_CAPTURE_CTRL)) begin
                next_capture_mode_select = i_pwdata[3:0];
            end
            if (addr_hit(i_paddr, OFS_IRQ_FLAG)) begin
                if (i_pwdata[IRQ_GATE_BIT]) begin
                    next_gate_event_flag = 1'b0;
                end
                if (i_pwdata[IRQ_CAPTURE_BIT]) begin
                    next_capture_flag = 1'b0;
                end
            end
            if (addr_hit(i_paddr, OFS_IRQ_ENABLE)) begin
                next_irq_enable_reg = i_pwdata[1:0];
            end
        end
        // Hardware sets override a same-cycle clear
        if (gate_level_status && !next_gate_level_status) begin
            next_gate_event_flag = 1'b1;
        end
        if (capture_event) begin
            next_capture_reg = o_main_timer;
            next_capture_flag = 1'b1;
        end
        next_gate_irq = next_gate_event_flag & next_irq_enable_reg[IRQ_GATE_BIT];
        next_capture_irq = next_capture_flag & next_irq_enable_reg[IRQ_CAPTURE_BIT];
    end

    // APB slave: one wait state, read data built during the first access cycle
    always_comb begin
        next_pready = i_psel && i_penable && !o_pready;
        next_pslverr = 1'b0;
        next_prdata = o_prdata;
        if (i_psel && i_penable && !o_pready) begin
            next_prdata = RESET_WORD;
            case (i_paddr)
                OFS_GATE_CTRL: begin
                    next_prdata[GC_TIMER_ON_BIT] = ctrl.timer_on;
                    next_prdata[GC_ENABLE_BIT] = ctrl.gate_enable;
                    next_prdata[GC_POLARITY_BIT] = ctrl.gate_polarity;
                    next_prdata[GC_TOGGLE_BIT] = ctrl.gate_toggle_enable;
                    next_prdata[GC_SINGLE_BIT] = ctrl.gate_single_pulse_enable;
                    next_prdata[GC_ARMED_BIT] = (sp_state != SP_IDLE);
                    next_prdata[GC_LEVEL_BIT] = gate_level_status;
                    next_prdata[GC_SOURCE_LSB +: 2] = ctrl.gate_source_select;
                end
                OFS_MAIN_TIMER: next_prdata[TIMER_W-1:0] = o_main_timer;
                OFS_CAPTURE: next_prdata[TIMER_W-1:0] = capture_reg;
                OFS_CAPTURE_CTRL: next_prdata[3:0] = capture_mode_select;
                OFS_IRQ_FLAG: begin
                    next_prdata[IRQ_GATE_BIT] = gate_event_flag;
                    next_prdata[IRQ_CAPTURE_BIT] = capture_flag;
                end
                OFS_IRQ_ENABLE: next_prdata[1:0] = irq_enable_reg;
                default: next_pslverr = 1'b1;
            endcase
        end else if (o_pready) begin
            next_pslverr = 1'b0;
        end
    end

    // APB answer registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_prdata <= RESET_WORD;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // Gate, timer, flag and capture registers
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            ctrl <= '0;
            sp_state <= SP_IDLE;
            capture_mode_select <= CAP_OFF;
            irq_enable_reg <= 2'h0;
            gate_event_flag <= 1'b0;
            capture_flag <= 1'b0;
            capture_reg <= 16'h0000;
            o_main_timer <= 16'h0000;
            ovf_prev <= 8'h00;
            cmp1_sync <= 1'b0;
            cmp2_sync <= 1'b0;
            gate_in_prev <= 1'b0;
            toggle_ff <= 1'b0;
            toggled_prev <= 1'b0;
            gate_level_status <= 1'b0;
            o_gate_irq <= 1'b0;
            o_capture_irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            sp_state <= next_sp_state;
            capture_mode_select <= next_capture_mode_select;
            irq_enable_reg <= next_irq_enable_reg;
            gate_event_flag <= next_gate_event_flag;
            capture_flag <= next_capture_flag;
            capture_reg <= next_capture_reg;
            o_main_timer <= next_main_timer;
            ovf_prev <= i_overflow_timer_count;
            cmp1_sync <= i_cmp.cmp1_out;
            cmp2_sync <= i_cmp.cmp2_out;
            gate_in_prev <= gate_in;
            toggle_ff <= next_toggle_ff;
            toggled_prev <= toggled;
            gate_level_status <= next_gate_level_status;
            o_gate_irq <= next_gate_irq;
            o_capture_irq <= next_capture_irq;
        end
    end
endmodule

// >>> test/tgc_asserts.sv
// Checker of bus handshake, timer step and interrupt relations
`timescale 1ns/1ns
module tgc_asserts
    import tgc_pkg::*;
#(
    parameter int TIMER_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_gate_input_pin,
    input wire logic [7:0] i_overflow_timer_count,
    input wire cmp_in_t i_cmp,
    input wire logic i_capture_pin,
    input wire logic i_pin_direction_bit,
    input wire logic i_port_latch,
    input wire logic [TIMER_W-1:0] o_main_timer,
    input wire logic o_gate_irq,
    input wire logic o_capture_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic acc_wr;
    assign acc_wr = i_psel && i_penable && o_pready && i_pwrite;
    a_ready_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready)
        else $error("pready not one cycle after access");
    a_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (i_psel && i_penable && !o_pready
        && i_paddr > OFS_IRQ_ENABLE |=> o_pslverr)
        else $error("unmapped access not refused");
    a_err_reads_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
        else $error("refused read not zero");
    a_prdata_holds: assert property (!o_pready |-> $stable(o_prdata))
        else $error("prdata changed outside answer");
    a_timer_step: assert property (!$past(acc_wr && i_paddr == OFS_MAIN_TIMER)
        |-> o_main_timer == $past(o_main_timer) || o_main_timer == $past(o_main_timer) + 1'b1)
        else $error("timer jumped");
    a_reset_clears: assert property (disable iff (1'b0) i_rst |=> !o_gate_irq
        && !o_capture_irq && !o_pready && o_main_timer == '0)
        else $error("outputs not cleared by reset");
    a_gate_irq_drop: assert property ($fell(o_gate_irq)
        |-> $past(acc_wr) || $past(acc_wr, 2))
        else $error("gate irq dropped without write");
    a_cap_irq_drop: assert property ($fell(o_capture_irq)
        |-> $past(acc_wr) || $past(acc_wr, 2))
        else $error("capture irq dropped without write");
endmodule
bind timer_gate_and_capture tgc_asserts #(.TIMER_W(TIMER_W)) i_tgc_asserts (.*);

// >>> test/far_side_model.sv
// Far-side model: overflow timer and comparator outputs
`timescale 1ns/1ns
module far_side_model
    import tgc_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire cmp_in_t i_cmp_req,
    output logic [7:0] o_overflow_timer_count,
    output cmp_in_t o_cmp
);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_overflow_timer_count <= OVF_TO;
            o_cmp <= '0;
        end else begin
            if (i_run) begin
                o_overflow_timer_count <= o_overflow_timer_count + 8'h01;
            end
            o_cmp <= i_cmp_req;
        end
    end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the gate and capture block
`timescale 1ns/1ns
module tb_top;
    import tgc_pkg::*;
    localparam logic [31:0] ARM = 32'h1 << GC_ARMED_BIT;
    localparam logic [31:0] SGL = 32'h1 << GC_SINGLE_BIT;
    localparam logic [31:0] TGL = 32'h1 << GC_TOGGLE_BIT;
    localparam logic [31:0] POL = 32'h1 << GC_POLARITY_BIT;
    localparam logic [31:0] GEN = 32'h1 << GC_ENABLE_BIT;
    localparam logic [31:0] ON = 32'h1 << GC_TIMER_ON_BIT;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, girq, cirq, dir, run, b;
    logic [2:0] sig;
    logic [7:0] paddr, ovf;
    logic [31:0] pwdata, prdata, v;
    logic [15:0] tmr;
    cmp_in_t creq, cmp;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] adr_q[$];
    int err_count = 0;
    int compares = 0;
    int n;
    integer seed = 32'h89f69c28;
    timer_gate_and_capture #(.TIMER_W(16)) i_timer_gate_and_capture (.i_sys_clk(clk),
        .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_gate_input_pin(sig[0]), .i_overflow_timer_count(ovf), .i_cmp(cmp),
        .i_capture_pin(sig[1]), .i_pin_direction_bit(dir), .i_port_latch(sig[2]),
        .o_main_timer(tmr), .o_gate_irq(girq), .o_capture_irq(cirq));
    far_side_model i_far_side_model (.i_sys_clk(clk), .i_rst(rst), .i_run(run),
        .i_cmp_req(creq), .o_overflow_timer_count(ovf), .o_cmp(cmp));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
        adr_q.push_back(a);
        exp_q.push_back(ex & m);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic pulse(input int w, input int cnt, input int hi, input int per);
        repeat (cnt) begin
            @(posedge clk);
            sig[w] <= 1'b1;
            repeat (hi) @(posedge clk);
            sig[w] <= 1'b0;
            repeat (per - hi - 1) @(posedge clk);
        end
    endtask
    task automatic span(input logic [31:0] d);
        repeat (3) @(posedge clk);
        @(negedge clk);
        v = tmr;
        repeat (10) @(negedge clk);
        chk("timer span", v + d, {16'h0, tmr});
        @(posedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && exp_q.size() > 0) begin
            chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(),
                prdata & msk_q.pop_front());
        end
    end
    initial begin
        #200000;
        err_count++;
        final_report;
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, sig, dir, run, creq} = '0;
        rst = 1'b1;
        dir = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a <= 24; a += 4) rd(a[7:0], 32'h0, a == 0 ? ~32'h4 : '1);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                v = $random(seed);
                sig[0] <= v[0];
                creq <= {v[1], v[2], v[3], v[4]};
                b = s == 0 ? v[0] : s == 2 ? v[1] : s == 3 ? v[3] : 1'b0;
                wr(OFS_GATE_CTRL, s | (p ? POL : 32'h0));
                rd(OFS_GATE_CTRL, s | (p ? POL : 32'h0) | ((b ^ !p) << 2), '1);
            end
        end
        sig[0] <= 1'b0;
        wr(OFS_GATE_CTRL, SRC_OVERFLOW | POL);
        wr(OFS_IRQ_FLAG, 32'h1);
        rd(OFS_IRQ_FLAG, 32'h0, 32'h1);
        run <= 1'b1;
        repeat (300) @(posedge clk);
        rd(OFS_IRQ_FLAG, 32'h1, 32'h1);
        wr(OFS_IRQ_ENABLE, 32'h1);
        repeat (3) @(posedge clk);
        chk("gate irq", 32'h1, girq);
        run <= 1'b0;
        wr(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_GATE_CTRL, ON);
        span(32'd10);
        wr(OFS_GATE_CTRL, ON | GEN | POL);
        span(32'd0);
        sig[0] <= 1'b1;
        span(32'd10);
        sig[0] <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = ON | GEN | POL | (k == 0 ? TGL : k == 1 ? SGL : SGL | TGL);
            wr(OFS_GATE_CTRL, v);
            if (k > 0) wr(OFS_GATE_CTRL, v | ARM);
            wr(OFS_MAIN_TIMER, 32'h0);
            pulse(0, k == 0 ? 2 : 3, 4, 10);
            repeat (4) @(posedge clk);
            rd(OFS_MAIN_TIMER, k == 1 ? 32'd4 : 32'd10, '1);
            rd(OFS_GATE_CTRL, 32'h0, ARM);
        end
        wr(OFS_GATE_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed) & 32'hffff;
            n = i < 2 ? 1 : i == 2 ? 4 : 16;
            wr(OFS_CAPTURE_CTRL, CAP_OFF);
            wr(OFS_MAIN_TIMER, v);
            wr(OFS_CAPTURE_CTRL, CAP_FALL + i);
            wr(OFS_IRQ_FLAG, 32'h2);
            pulse(1, n - 1, 2, 4);
            repeat (3) @(posedge clk);
            rd(OFS_IRQ_FLAG, 32'h0, 32'h2);
            pulse(1, 1, 2, 4);
            repeat (3) @(posedge clk);
            rd(OFS_IRQ_FLAG, 32'h2, 32'h2);
            rd(OFS_CAPTURE, v, '1);
        end
        wr(OFS_IRQ_ENABLE, 32'h2);
        repeat (3) @(posedge clk);
        chk("capture irq", 32'h1, cirq);
        wr(OFS_IRQ_FLAG, 32'h2);
        repeat (3) @(posedge clk);
        chk("capture irq", 32'h0, cirq);
        dir <= 1'b0;
        sig[1] <= 1'b1;
        wr(OFS_CAPTURE_CTRL, CAP_RISE);
        for (int i = 0; i < 2; i++) begin
            v = $random(seed) & 32'hffff;
            wr(OFS_MAIN_TIMER, v);
            pulse(2, 1, 2, 4);
        end
        repeat (3) @(posedge clk);
        rd(OFS_CAPTURE, v, '1);
        repeat (2) @(posedge clk);
        final_report;
    end
endmodule
